// file: skip_table_xor_instr_exec.sv
// Function
// RULE1 - Nibble exchange puts swapped memory byte into accumulator, no flags touched
// RULE2 - Taken skip discards prefetched instruction, adds one dummy cycle: two cycles
// RULE3 - Skip-on-null skips when whole memory byte is zero, no writes
// RULE4 - Copy-and-skip loads byte into accumulator, skips when zero, no flags
// RULE5 - Bit-test skip skips when selected memory bit is zero, no flags
// RULE6 - Current-page table read: low byte to memory, high byte to table-high
// RULE7 - Final-page table read: same, but from the last program page
// RULE8 - XOR accumulator with memory, result to accumulator, zero flag only
// RULE9 - XOR accumulator with memory, result back to memory, zero flag only
// RULE10 - XOR accumulator with immediate, result to accumulator, zero flag only
// RULE11 - Zero flag set when XOR result is zero, cleared otherwise
`timescale 1ns/1ps
`include "exec_cfg.svh"

module skip_table_xor_instr_exec #(
    parameter int PC_W = 13,
    parameter int PT_W = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire exec_pkg::instr_t      instr_i,
    input  wire logic [7:0]            mem_rdata_i,
    input  wire logic [PC_W-1:0]       pc_i,
    input  wire logic [PT_W-1:0]       table_pointer_reg_i,
    input  wire logic [15:0]           rom_rdata_i,
    output logic                       ready_o,
    output exec_pkg::mem_wr_t          mem_wr_o,
    output logic [PC_W-1:0]            rom_addr_o,
    output logic                       discard_prefetch_o,
    output logic [7:0]                 acc_o,
    output logic                       zero_flag_o,
    output logic [7:0]                 table_high_byte_reg_o
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic is_op(input exec_pkg::instr_t i, input logic [3:0] c);
        is_op = i.valid && (i.opcode == c);
    endfunction

    exec_pkg::exec_state_t state;
    exec_pkg::exec_state_t next_state;

    wire logic run           = (state == exec_pkg::ST_RUN);
    wire logic nibble_exchange_to_accumulator_op = run && is_op(instr_i, `OPC_NIBBLE_XCHG);
    wire logic skip_on_null_op      = run && is_op(instr_i, `OPC_SKIP_NULL);
    wire logic copy_skip_on_null_op = run && is_op(instr_i, `OPC_COPY_SKIP);
    wire logic bit_skip_op          = run && is_op(instr_i, `OPC_BIT_SKIP);
    wire logic table_read_current_page_op = run && is_op(instr_i, `OPC_TAB_CUR);
    wire logic table_read_final_page_op   = run && is_op(instr_i, `OPC_TAB_FIN);
    wire logic xor_acc_op           = run && is_op(instr_i, `OPC_XOR_ACC);
    wire logic exclusive_or_to_memory_op = run && is_op(instr_i, `OPC_XOR_MEM);
    wire logic xor_imm_op           = run && is_op(instr_i, `OPC_XOR_IMM);
    wire logic table_op = table_read_current_page_op || table_read_final_page_op;

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    // Whole byte zero and selected bit zero tests
    wire logic byte_null = (mem_rdata_i == 8'h00);
    wire logic bit_null  = ~mem_rdata_i[instr_i.bit_sel];
    wire logic skip_take = ((skip_on_null_op || copy_skip_on_null_op) && byte_null) // RULE3 RULE4
                        || (bit_skip_op && bit_null); // RULE5

    wire logic [7:0] xor_mem = acc_o ^ mem_rdata_i;
    wire logic [7:0] xor_imm = acc_o ^ instr_i.imm;
    wire logic [7:0] xor_res = xor_imm_op ? xor_imm : xor_mem;
    wire logic xor_any = xor_acc_op || exclusive_or_to_memory_op || xor_imm_op;

    // Table address: pointer in the low bits, page from pc or forced to the last page
    logic [PC_W-1:0] tab_addr_reg;
    wire logic [PC_W-PT_W-1:0] cur_page = pc_i[PC_W-1:PT_W];
    wire logic [PC_W-PT_W-1:0] fin_page = '1;
    wire logic [PC_W-1:0] tab_addr = table_read_final_page_op
                                   ? {fin_page, table_pointer_reg_i}  // RULE7
                                   : {cur_page, table_pointer_reg_i}; // RULE6

    // Core stalls fetch while a dummy or table cycle runs
    assign ready_o = run;
    assign discard_prefetch_o = (state == exec_pkg::ST_DUMMY); // RULE2
    assign rom_addr_o = tab_addr_reg;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Table reads take a second cycle for the program memory access
    always_comb begin
        next_state = exec_pkg::ST_RUN;
        case (state)
            exec_pkg::ST_RUN: begin
                if (skip_take) begin
                    next_state = exec_pkg::ST_DUMMY; // RULE2
                end else if (table_op) begin
                    next_state = exec_pkg::ST_TABLE;
                end
            end
            // Dummy and table states have no exit condition: one cycle each
            default: next_state = exec_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= exec_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tab_addr_reg <= '0;
        end else if (table_op) begin
            tab_addr_reg <= tab_addr; // RULE6 RULE7
        end
    end

    // ----------------------------------------------------------------
    // Architectural state
    // ----------------------------------------------------------------
    // Accumulator; skip-on-null and bit test leave it alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_o <= `ACC_RST;
        end else if (nibble_exchange_to_accumulator_op) begin
            acc_o <= {mem_rdata_i[3:0], mem_rdata_i[7:4]}; // RULE1
        end else if (copy_skip_on_null_op) begin
            acc_o <= mem_rdata_i; // RULE4
        end else if (xor_acc_op || xor_imm_op) begin
            acc_o <= xor_res; // RULE8 RULE10
        end
    end

    // Zero flag moves only for the exclusive-OR forms
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zero_flag_o <= `ZERO_RST;
        end else if (xor_any) begin
            zero_flag_o <= (xor_res == 8'h00); // RULE11
        end
    end

    // High byte of the program word lands in the table-high register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_high_byte_reg_o <= `TABLE_HIGH_RST;
        end else if (state == exec_pkg::ST_TABLE) begin
            table_high_byte_reg_o <= rom_rdata_i[15:8]; // RULE6 RULE7
        end
    end

    // Memory write: registered so data leaves a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_wr_o <= '0;
        end else if (state == exec_pkg::ST_TABLE) begin
            mem_wr_o <= '{we: 1'b1, wdata: rom_rdata_i[7:0]}; // RULE6 RULE7
        end else if (exclusive_or_to_memory_op) begin
            mem_wr_o <= '{we: 1'b1, wdata: xor_mem}; // RULE9
        end else begin
            // Data holds after the pulse so a slow memory still sees settled bits
            mem_wr_o <= '{we: 1'b0, wdata: mem_wr_o.wdata};
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    swap_result_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        nibble_exchange_to_accumulator_op |=> acc_o == {$past(mem_rdata_i[3:0]),
            $past(mem_rdata_i[7:4])} && $stable(zero_flag_o) && !mem_wr_o.we)
        else $error("nibble exchange result wrong");
    skip_dummy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        skip_take |=> discard_prefetch_o ##1 ready_o)
        else $error("skip did not take two cycles");
    noskip_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        (run && !skip_take && !table_op) |=> ready_o)
        else $error("non skip took extra cycle");
    null_skip_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        skip_on_null_op |-> (skip_take == byte_null) ##1 (!mem_wr_o.we && $stable(acc_o)))
        else $error("skip on null wrong");
    copy_skip_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        copy_skip_on_null_op |=> acc_o == $past(mem_rdata_i) && $stable(zero_flag_o)
                                 && (discard_prefetch_o == (acc_o == 8'h00)))
        else $error("copy and skip wrong");
    bit_skip_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        bit_skip_op |-> (skip_take == !mem_rdata_i[instr_i.bit_sel]) ##1 $stable(zero_flag_o))
        else $error("bit skip wrong");
    table_cur_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        table_read_current_page_op |=> rom_addr_o == {$past(pc_i[PC_W-1:PT_W]),
                                                       $past(table_pointer_reg_i)}
        ##1 mem_wr_o.we && mem_wr_o.wdata == $past(rom_rdata_i[7:0])
            && table_high_byte_reg_o == $past(rom_rdata_i[15:8]))
        else $error("current page table read wrong");
    table_fin_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        table_read_final_page_op |=> &rom_addr_o[PC_W-1:PT_W] && $stable(zero_flag_o))
        else $error("final page table read wrong");
    xor_acc_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        xor_acc_op |=> acc_o == ($past(acc_o) ^ $past(mem_rdata_i)) && !mem_wr_o.we)
        else $error("xor to accumulator wrong");
    xor_mem_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        exclusive_or_to_memory_op |=> mem_wr_o.we && $stable(acc_o)
            && mem_wr_o.wdata == ($past(acc_o) ^ $past(mem_rdata_i)))
        else $error("xor to memory wrong");
    xor_imm_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        xor_imm_op |=> acc_o == ($past(acc_o) ^ $past(instr_i.imm)))
        else $error("xor immediate wrong");
    zero_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        xor_any |=> zero_flag_o == ($past(exclusive_or_to_memory_op)
                                    ? (mem_wr_o.wdata == 8'h00) : (acc_o == 8'h00)))
        else $error("zero flag wrong");
    // Instructions offered while busy must leave accumulator and flag alone
    busy_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        !ready_o |=> $stable(acc_o) && $stable(zero_flag_o))
        else $error("instruction taken while busy");
    dummy_single_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        discard_prefetch_o |=> !discard_prefetch_o)
        else $error("dummy cycle longer than one");

endmodule

// file: exec_cfg.svh
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
// Operation codes on the decoded-op port
`define OPC_NIBBLE_XCHG 4'h1
`define OPC_SKIP_NULL   4'h2
`define OPC_COPY_SKIP   4'h3
`define OPC_BIT_SKIP    4'h4
`define OPC_TAB_CUR     4'h5
`define OPC_TAB_FIN     4'h6
`define OPC_XOR_ACC     4'h7
`define OPC_XOR_MEM     4'h8
`define OPC_XOR_IMM     4'h9
// Reset values
`define ACC_RST         8'h00
`define ZERO_RST        1'b0
`define TABLE_HIGH_RST  8'h00
`endif

// file: exec_pkg.sv
package exec_pkg;
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_TABLE = 2'b01,
        ST_DUMMY = 2'b11
    } exec_state_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] opcode;
        logic [2:0] bit_sel;
        logic [7:0] imm;
    } instr_t;

    typedef struct packed {
        logic       we;
        logic [7:0] wdata;
    } mem_wr_t;
endpackage

// file: tb_skip_table_xor_instr_exec.sv
`timescale 1ns/1ps
`include "exec_cfg.svh"
// ----------------------------------------
// Compare helper
// ----------------------------------------
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_skip_table_xor_instr_exec;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    exec_pkg::instr_t  instr = '0;
    logic [7:0]        mem_rdata = 8'h00;
    logic [12:0]       pc = 13'h1a37;
    logic [7:0]        ptr = 8'h9c;
    logic [15:0]       rom_rdata = 16'h0000;
    logic              ready;
    exec_pkg::mem_wr_t mem_wr;
    logic [12:0]       rom_addr;
    logic              discard;
    logic [7:0]        acc;
    logic              zero;
    logic [7:0]        table_high;
    int                error_cnt = 0;
    int                num_checks = 0;
    int                cyc = 0;

    skip_table_xor_instr_exec skip_table_xor_instr_exec_inst (
        .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr), .mem_rdata_i(mem_rdata),
        .pc_i(pc), .table_pointer_reg_i(ptr), .rom_rdata_i(rom_rdata),
        .ready_o(ready), .mem_wr_o(mem_wr), .rom_addr_o(rom_addr),
        .discard_prefetch_o(discard), .acc_o(acc), .zero_flag_o(zero),
        .table_high_byte_reg_o(table_high));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    always #2.5 clk_i = ~clk_i;
    // Whole run is a few dozen cycles; 2000 leaves ample slack
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 2000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One instruction across one rising edge; valid stays up so that back to back
    // calls touch each signal only once per time step
    task automatic issue(input logic [3:0] op, input logic [2:0] bs,
                         input logic [7:0] imm, input logic [7:0] md);
        instr = '{valid: 1'b1, opcode: op, bit_sel: bs, imm: imm};
        mem_rdata = md;
        @(negedge clk_i);
    endtask

    // Drop the request and let one rising edge pass with the bus quiet
    task automatic idle_bus();
        instr.valid = 1'b0;
        mem_rdata = ~mem_rdata; // Stale memory byte must not be reused
        @(negedge clk_i);
    endtask

    task automatic t_reset();
        `CHK({acc, zero, table_high, rom_addr, mem_wr.we, discard, ready},
             {8'h00, 1'b0, 8'h00, 13'h0000, 3'b001})
        $display("reset test done");
    endtask

    // Back to back XOR forms, zero flag both ways
    task automatic t_xor();
        issue(`OPC_XOR_IMM, 3'h0, 8'h5a, 8'hff);
        `CHK({acc, zero, mem_wr.we}, {8'h5a, 1'b0, 1'b0})
        issue(`OPC_XOR_MEM, 3'h0, 8'h00, 8'h3c);
        `CHK({mem_wr.we, mem_wr.wdata, acc, zero}, {1'b1, 8'h66, 8'h5a, 1'b0})
        issue(`OPC_XOR_ACC, 3'h0, 8'h00, 8'h5a);
        `CHK({acc, zero, mem_wr.we}, {8'h00, 1'b1, 1'b0})
        idle_bus();
        $display("xor test done");
    endtask

    // Zero flag is left at 1 so any stray update shows
    task automatic t_swap();
        issue(`OPC_NIBBLE_XCHG, 3'h0, 8'h00, 8'ha5);
        `CHK({acc, zero, mem_wr.we, discard}, {8'h5a, 1'b1, 1'b0, 1'b0})
        idle_bus();
        $display("swap test done");
    endtask

    task automatic skip_case(input logic [3:0] op, input logic [2:0] bs,
                             input logic [7:0] md, input logic skip, input logic [7:0] ea);
        issue(op, bs, 8'h00, md);
        `CHK({discard, ready, mem_wr.we, zero, acc}, {skip, ~skip, 1'b0, 1'b1, ea})
        if (skip) begin
            // Offered during the dummy cycle, must be refused
            issue(`OPC_XOR_IMM, 3'h0, 8'hff, 8'h00);
            `CHK({discard, ready, acc, zero}, {1'b0, 1'b1, ea, 1'b1})
        end
        idle_bus();
    endtask

    task automatic t_skips();
        skip_case(`OPC_SKIP_NULL, 3'h0, 8'h00, 1'b1, 8'h5a);
        skip_case(`OPC_SKIP_NULL, 3'h0, 8'h80, 1'b0, 8'h5a);
        skip_case(`OPC_BIT_SKIP, 3'h3, 8'hf7, 1'b1, 8'h5a);
        skip_case(`OPC_BIT_SKIP, 3'h3, 8'h08, 1'b0, 8'h5a);
        skip_case(`OPC_COPY_SKIP, 3'h0, 8'h42, 1'b0, 8'h42);
        skip_case(`OPC_COPY_SKIP, 3'h0, 8'h00, 1'b1, 8'h00);
        $display("skip test done");
    endtask

    task automatic table_case(input logic [3:0] op, input logic [4:0] page,
                              input logic [15:0] word);
        issue(op, 3'h0, 8'h00, 8'h11);
        `CHK({rom_addr, ready, mem_wr.we}, {page, ptr, 1'b0, 1'b0})
        rom_rdata = word;
        @(negedge clk_i);
        `CHK({mem_wr.we, mem_wr.wdata, table_high}, {1'b1, word[7:0], word[15:8]})
        `CHK({ready, acc, zero}, {1'b1, 8'h00, 1'b1})
        rom_rdata = ~word;
        idle_bus();
        `CHK({mem_wr.we, table_high, rom_addr}, {1'b0, word[15:8], page, ptr})
    endtask

    task automatic t_table();
        table_case(`OPC_TAB_CUR, 5'h1a, 16'hbeef);
        table_case(`OPC_TAB_FIN, 5'h1f, 16'h1234);
        $display("table test done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_xor();
        t_swap();
        t_skips();
        t_table();
        repeat (2) @(negedge clk_i);
        complete_run();
    end
endmodule
